/* adp_pkg.sv */
// Shared constants and types for the converter digital output port
`default_nettype none
package adp_pkg;

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  localparam int WORD_W        = 16;
  localparam int MSB_POS       = 15;
  localparam int LSB_POS       = 0;
  localparam int PIPE_LATENCY  = 7;
  localparam int PIN_SYNC_W    = 26;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_STATUS  = 8'h00;
  localparam logic [7:0]  OFF_MASK    = 8'h04;
  localparam logic [7:0]  OFF_LAST    = 8'h08;
  localparam logic [7:0]  OFF_PINS    = 8'h0C;
  localparam logic [7:0]  OFF_COUNT   = 8'h10;

  // Event bits in status and mask
  localparam int          EV_W        = 3;
  localparam int          EV_WORD     = 0;
  localparam int          EV_RANGE    = 1;
  localparam int          EV_PDN      = 2;
  localparam logic [2:0]  STATUS_RST  = 3'h0;
  localparam logic [2:0]  MASK_RST    = 3'h0;
  localparam logic [31:0] COUNT_RST   = 32'h0000_0000;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_GND        = 2'b00,
    MODE_THIRD      = 2'b01,
    MODE_TWO_THIRDS = 2'b10,
    MODE_FULL       = 2'b11
  } adp_mode_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } adp_rd_state_t;

  typedef struct packed {
    logic              over;
    logic [WORD_W-1:0] word;
  } adp_sample_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       gain;
    logic       scramble;
    logic       dither;
    logic       oe_n;
    logic       pdn;
  } adp_pins_t;

endpackage : adp_pkg
`default_nettype wire

/* adp_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs
`default_nettype none
module adp_sync
  import adp_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adp_sync_state_t;

  adp_sync_state_t q;
  adp_sync_state_t d;

  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.s2;

endmodule : adp_sync
`default_nettype wire

/* adp_delay_line.sv */
// Shift register that advances one stage per sample edge
`default_nettype none
module adp_delay_line
  import adp_pkg::*;
#(
  parameter int W     = 17,
  parameter int DEPTH = PIPE_LATENCY
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Stream
  input  wire logic         adv,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] stg;
  } adp_dl_state_t;

  adp_dl_state_t q;
  adp_dl_state_t d;

  always_comb
  begin
    d = q;
    if (adv)
    begin
      d.stg[0] = din;
      for (int i = 1; i < DEPTH; i++)
        d.stg[i] = q.stg[i-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.stg[DEPTH-1];

endmodule : adp_delay_line
`default_nettype wire

/* adp_output_port.sv */
// Converter digital output port: sampling, latency, format, drivers, registers
//
// Behaviour
// - Capture input code at each encode rise
// - Output word seven encode cycles later
// - Encode high when positive exceeds negative
// - Power-down: analog off, outputs high impedance
// - Dither pin high enables dither
// - Sixteen-bit word, bit 15 is MSB
// - Strobes toggle at rate, complementary
// - Range flag high on over/underflow
// - Output enable low drives outputs
// - Mode low levels binary, high twos
// - Duty stabiliser off only at ground
// - Scramble XORs bits 1-15 with bit 0
// - Gain pin selects unity or 1.5
`default_nettype none
module adp_output_port
  import adp_pkg::*;
(
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              NRST,
  // Encode clock pair
  input  wire logic              SAMPLE_CLOCK_POS,
  input  wire logic              SAMPLE_CLOCK_NEG,
  // Static control pins
  input  wire logic              POWER_DOWN_PIN,
  input  wire logic              OUTPUT_ENABLE_N_PIN,
  input  wire logic              DITHER_ENABLE_PIN,
  input  wire logic              OUTPUT_SCRAMBLE_SELECT,
  input  wire logic              INPUT_GAIN_SELECT,
  input  wire logic [1:0]        FORMAT_MODE_LEVEL,
  // Quantised result from the converter core
  input  wire logic [WORD_W-1:0] CONVERTED_CODE,
  input  wire logic              CONVERTED_OVER,
  // Sample outputs
  output logic      [WORD_W-1:0] SAMPLE_WORD_BITS_O,
  output logic                   SAMPLE_WORD_BITS_OE,
  output logic                   DATA_VALID_STROBE_POS_O,
  output logic                   DATA_VALID_STROBE_POS_OE,
  output logic                   DATA_VALID_STROBE_NEG_O,
  output logic                   DATA_VALID_STROBE_NEG_OE,
  output logic                   RANGE_EXCEEDED_FLAG_O,
  output logic                   RANGE_EXCEEDED_FLAG_OE,
  // Analog core controls
  output logic                   ANALOG_POWER_DOWN,
  output logic                   DITHER_ACTIVE,
  output logic                   GAIN_HIGH_RANGE,
  output logic                   DUTY_STABILIZER_ON,
  // Interrupt
  output logic                   IRQ,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic      [1:0]        S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic      [31:0]       S_AXI_RDATA,
  output logic      [1:0]        S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    enc_prev;
    logic                    pdn_prev;
    adp_sample_t             out;
    logic                    strobe_pos;
    logic                    drive;
    logic                    pdn;
    logic                    dither;
    logic                    gain;
    logic                    dcs;
    logic [EV_W-1:0]         status;
    logic [EV_W-1:0]         mask;
    logic [31:0]             count;
    logic                    irq;
    logic                    aw_got;
    logic [ADDR_W-1:0]       awaddr;
    logic                    w_got;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    adp_rd_state_t           rd;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } adp_top_state_t;

  adp_top_state_t q;
  adp_top_state_t d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Encode and code share one synchroniser so they stay cycle aligned
  logic [PIN_SYNC_W-1:0] pins_raw;
  logic [PIN_SYNC_W-1:0] pins_s;
  adp_pins_t             pins;
  adp_sample_t           code_s;
  logic                  enc_pos_s;
  logic                  enc_neg_s;

  assign pins_raw = {SAMPLE_CLOCK_POS, SAMPLE_CLOCK_NEG,
                     FORMAT_MODE_LEVEL, INPUT_GAIN_SELECT, OUTPUT_SCRAMBLE_SELECT,
                     DITHER_ENABLE_PIN, OUTPUT_ENABLE_N_PIN, POWER_DOWN_PIN,
                     CONVERTED_OVER, CONVERTED_CODE};

  adp_sync #(
    .W    (PIN_SYNC_W)
  ) u_pin_sync (
    .clk  (SYS_CLK),
    .rst_n(NRST),
    .din  (pins_raw),
    .dout (pins_s)
  );

  assign enc_pos_s = pins_s[25];
  assign enc_neg_s = pins_s[24];
  assign pins      = pins_s[23:17];
  assign code_s    = pins_s[16:0];

  // ----------------------------------------------------------------
  // Encode edge and pipeline
  // ----------------------------------------------------------------
  logic        enc_high;
  logic        enc_rise;
  adp_sample_t pipe_out;

  assign enc_high = enc_pos_s & ~enc_neg_s;
  assign enc_rise = enc_high & ~q.enc_prev;

  adp_delay_line #(
    .W    ($bits(adp_sample_t)),
    .DEPTH(PIPE_LATENCY)
  ) u_pipe (
    .clk  (SYS_CLK),
    .rst_n(NRST),
    .adv  (enc_rise),
    .din  (code_s),
    .dout (pipe_out)
  );

  // ----------------------------------------------------------------
  // Output formatting
  // ----------------------------------------------------------------
  logic              twos;
  logic [WORD_W-1:0] fmt_word;

  assign twos = (pins.mode == MODE_TWO_THIRDS) || (pins.mode == MODE_FULL);

  always_comb
  begin
    fmt_word          = pipe_out.word;
    fmt_word[MSB_POS] = pipe_out.word[MSB_POS] ^ twos;
    if (pins.scramble)
      fmt_word[MSB_POS:1] = fmt_word[MSB_POS:1] ^ {(WORD_W-1){fmt_word[LSB_POS]}};
  end

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              aw_have;
  logic              w_have;
  logic              do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   ev_clr;

  assign S_AXI_AWREADY = ~q.aw_got & ~q.bvalid;
  assign S_AXI_WREADY  = ~q.w_got & ~q.bvalid;
  assign S_AXI_ARREADY = (q.rd == RD_IDLE);

  assign aw_hs    = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs     = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_hs    = S_AXI_ARVALID & S_AXI_ARREADY;
  assign aw_have  = q.aw_got | aw_hs;
  assign w_have   = q.w_got | w_hs;
  assign do_write = aw_have & w_have & ~q.bvalid;
  assign wr_addr  = q.aw_got ? q.awaddr : S_AXI_AWADDR;
  assign wr_data  = q.w_got ? q.wdata : S_AXI_WDATA;
  assign wr_strb  = q.w_got ? q.wstrb : S_AXI_WSTRB;
  assign rd_addr  = {S_AXI_ARADDR[ADDR_W-1:2], 2'b00};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d          = q;
    ev_set     = '0;
    ev_clr     = '0;
    d.enc_prev = enc_high;
    d.pdn_prev = pins.pdn;

    // Static controls follow their pins
    d.pdn    = pins.pdn;
    d.dither = pins.dither;
    d.gain   = pins.gain;
    d.dcs    = (pins.mode != MODE_GND);
    d.drive  = ~pins.pdn & ~pins.oe_n;

    // Strobe falls with each new word, rises mid-period when it is stable
    d.strobe_pos = ~enc_high;

    if (enc_rise)
    begin
      d.out.word = fmt_word;
      d.out.over = pipe_out.over;
      d.count    = q.count + 32'h0000_0001;
      ev_set[EV_WORD]  = 1'b1;
      ev_set[EV_RANGE] = pipe_out.over;
    end
    if (pins.pdn != q.pdn_prev)
      ev_set[EV_PDN] = 1'b1;

    // Write channel: address and data in either order
    if (aw_hs)
    begin
      d.aw_got = 1'b1;
      d.awaddr = S_AXI_AWADDR;
    end
    if (w_hs)
    begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    if (do_write)
    begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      case ({wr_addr[ADDR_W-1:2], 2'b00})
        OFF_MASK:
        begin
          if (wr_strb[0])
            d.mask = wr_data[EV_W-1:0];
        end
        OFF_STATUS, OFF_LAST, OFF_PINS, OFF_COUNT:
          d.bresp = RESP_OKAY;
        default:
          d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && S_AXI_BREADY)
      d.bvalid = 1'b0;

    // Read channel
    case (q.rd)
      RD_IDLE:
      begin
        if (ar_hs)
        begin
          d.rd    = RD_DATA;
          d.rresp = RESP_OKAY;
          d.rdata = 32'h0000_0000;
          case (rd_addr)
            OFF_STATUS:
            begin
              d.rdata[EV_W-1:0] = q.status;
              ev_clr            = q.status;
            end
            OFF_MASK:
              d.rdata[EV_W-1:0] = q.mask;
            OFF_LAST:
              d.rdata[$bits(adp_sample_t)-1:0] = q.out;
            OFF_PINS:
              d.rdata[$bits(adp_pins_t)-1:0] = pins;
            OFF_COUNT:
              d.rdata = q.count;
            default:
              d.rresp = RESP_SLVERR;
          endcase
        end
      end
      RD_DATA:
      begin
        if (S_AXI_RREADY)
          d.rd = RD_IDLE;
      end
      default:
        d.rd = RD_IDLE;
    endcase

    // Sticky events; a new event beats a read-clear in the same cycle
    d.status = (q.status & ~ev_clr) | ev_set;
    d.irq    = |(d.status & q.mask);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      q        <= '0;
      q.status <= STATUS_RST;
      q.mask   <= MASK_RST;
      q.count  <= COUNT_RST;
      q.rd     <= RD_IDLE;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SAMPLE_WORD_BITS_O       = q.out.word;
  assign SAMPLE_WORD_BITS_OE      = q.drive;
  assign DATA_VALID_STROBE_POS_O  = q.strobe_pos;
  assign DATA_VALID_STROBE_POS_OE = q.drive;
  assign DATA_VALID_STROBE_NEG_O  = ~q.strobe_pos;
  assign DATA_VALID_STROBE_NEG_OE = q.drive;
  assign RANGE_EXCEEDED_FLAG_O    = q.out.over;
  assign RANGE_EXCEEDED_FLAG_OE   = q.drive;
  assign ANALOG_POWER_DOWN        = q.pdn;
  assign DITHER_ACTIVE            = q.dither;
  assign GAIN_HIGH_RANGE          = q.gain;
  assign DUTY_STABILIZER_ON       = q.dcs;
  assign IRQ                      = q.irq;
  assign S_AXI_BVALID             = q.bvalid;
  assign S_AXI_BRESP              = q.bresp;
  assign S_AXI_RVALID             = (q.rd == RD_DATA);
  assign S_AXI_RDATA              = q.rdata;
  assign S_AXI_RRESP              = q.rresp;

endmodule : adp_output_port
`default_nettype wire

/* adp_output_port_sva.sv */
// Port-level assertions for the converter digital output port
`default_nettype none
module adp_output_port_sva
  import adp_pkg::*;
(
  // Clock and reset
  input wire logic              SYS_CLK,
  input wire logic              NRST,
  // Pins
  input wire logic              POWER_DOWN_PIN,
  input wire logic              OUTPUT_ENABLE_N_PIN,
  input wire logic              DITHER_ENABLE_PIN,
  input wire logic [1:0]        FORMAT_MODE_LEVEL,
  // Outputs
  input wire logic [WORD_W-1:0] SAMPLE_WORD_BITS_O,
  input wire logic              SAMPLE_WORD_BITS_OE,
  input wire logic              DATA_VALID_STROBE_POS_O,
  input wire logic              DATA_VALID_STROBE_POS_OE,
  input wire logic              DATA_VALID_STROBE_NEG_O,
  input wire logic              DATA_VALID_STROBE_NEG_OE,
  input wire logic              RANGE_EXCEEDED_FLAG_O,
  input wire logic              ANALOG_POWER_DOWN,
  input wire logic              DITHER_ACTIVE,
  input wire logic              DUTY_STABILIZER_ON,
  input wire logic              IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  // Six cycles cover the two-flop pin synchroniser plus the output register with margin
  a_strobe_inverse: assert property (DATA_VALID_STROBE_NEG_O == !DATA_VALID_STROBE_POS_O)
    else $error("strobe pair not complementary");
  a_oe_shared: assert property (DATA_VALID_STROBE_POS_OE == SAMPLE_WORD_BITS_OE
    && DATA_VALID_STROBE_NEG_OE == SAMPLE_WORD_BITS_OE) else $error("enables differ");
  a_pdn_hiz: assert property (POWER_DOWN_PIN [*6] |-> !SAMPLE_WORD_BITS_OE && ANALOG_POWER_DOWN)
    else $error("outputs driven in power down");
  a_disable_hiz: assert property (OUTPUT_ENABLE_N_PIN [*6] |-> !SAMPLE_WORD_BITS_OE)
    else $error("outputs driven while disabled");
  a_enable_drives: assert property ((!POWER_DOWN_PIN && !OUTPUT_ENABLE_N_PIN) [*6]
    |-> SAMPLE_WORD_BITS_OE) else $error("outputs not driven");
  a_dither_follows: assert property ($stable(DITHER_ENABLE_PIN) [*6]
    |-> DITHER_ACTIVE == DITHER_ENABLE_PIN) else $error("dither level wrong");
  a_duty_by_mode: assert property ($stable(FORMAT_MODE_LEVEL) [*6]
    |-> DUTY_STABILIZER_ON == (FORMAT_MODE_LEVEL != 2'h0)) else $error("duty stabiliser wrong");
  a_word_aligned: assert property ($changed({RANGE_EXCEEDED_FLAG_O, SAMPLE_WORD_BITS_O})
    |-> !DATA_VALID_STROBE_POS_O) else $error("word or flag moved off strobe low");

  c_strobe: cover property ($rose(DATA_VALID_STROBE_POS_O) && SAMPLE_WORD_BITS_OE);
  c_irq: cover property ($rose(IRQ));
  c_pdn: cover property (ANALOG_POWER_DOWN && !SAMPLE_WORD_BITS_OE);
endmodule : adp_output_port_sva

bind adp_output_port adp_output_port_sva u_sva (.*);
`default_nettype wire

/* adp_capture_model.sv */
// Capture logic that latches output words on the positive strobe rise
`default_nettype none
module adp_capture_model
  import adp_pkg::*;
(
  // Wires from the port
  input  wire logic [WORD_W-1:0] word_i,
  input  wire logic              word_oe,
  input  wire logic              over_i,
  input  wire logic              strobe_pos,
  input  wire logic              strobe_oe,
  input  wire logic              scramble,
  // Captured result
  output var adp_sample_t        cap_q,
  output var int                 cap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] bus;
  logic [WORD_W-1:0] last = '0;

  // Released bus shows no stale word
  assign bus = word_oe ? word_i : ~last;
  initial cap_cnt = 0;

  always @(posedge strobe_pos)
  begin
    if (strobe_oe)
    begin
      last = bus;
      cap_q.over = over_i;
      cap_q.word = scramble ? {bus[15:1] ^ {15{bus[0]}}, bus[0]} : bus;
      cap_cnt = cap_cnt + 1;
    end
  end
endmodule : adp_capture_model
`default_nettype wire

/* adp_output_port_tb.sv */
// Self-checking bench for the converter digital output port
`default_nettype none
module adp_output_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adp_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic              SYS_CLK = 1'b0;
  logic              NRST = 1'b0;
  logic              SAMPLE_CLOCK_POS = 1'b0;
  logic              SAMPLE_CLOCK_NEG, POWER_DOWN_PIN, OUTPUT_ENABLE_N_PIN, DITHER_ENABLE_PIN;
  logic              OUTPUT_SCRAMBLE_SELECT, INPUT_GAIN_SELECT, CONVERTED_OVER, IRQ;
  logic [1:0]        FORMAT_MODE_LEVEL, S_AXI_BRESP, S_AXI_RRESP, rs;
  logic [WORD_W-1:0] CONVERTED_CODE, SAMPLE_WORD_BITS_O;
  logic              SAMPLE_WORD_BITS_OE, DATA_VALID_STROBE_POS_O, DATA_VALID_STROBE_POS_OE;
  logic              DATA_VALID_STROBE_NEG_O, DATA_VALID_STROBE_NEG_OE, RANGE_EXCEEDED_FLAG_O;
  logic              RANGE_EXCEEDED_FLAG_OE, ANALOG_POWER_DOWN, DITHER_ACTIVE, GAIN_HIGH_RANGE;
  logic              DUTY_STABILIZER_ON, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic              S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic              S_AXI_RVALID, S_AXI_RREADY;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]       S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [3:0]        S_AXI_WSTRB = 4'hF;
  logic [16:0]       src = '0;
  adp_pins_t         pins;
  adp_sample_t       cap;
  int                cap_cnt, cap_rise, n_rise = 0, n_mismatch = 0, cmp_count = 0;

  assign {FORMAT_MODE_LEVEL, INPUT_GAIN_SELECT, OUTPUT_SCRAMBLE_SELECT} = pins[6:3];
  assign {DITHER_ENABLE_PIN, OUTPUT_ENABLE_N_PIN, POWER_DOWN_PIN} = pins[2:0];
  assign {CONVERTED_OVER, CONVERTED_CODE} = src;
  assign SAMPLE_CLOCK_NEG = !SAMPLE_CLOCK_POS;

  adp_output_port DUT (.*);
  adp_capture_model u_cap (.word_i(SAMPLE_WORD_BITS_O), .word_oe(SAMPLE_WORD_BITS_OE),
    .over_i(RANGE_EXCEEDED_FLAG_O), .strobe_pos(DATA_VALID_STROBE_POS_O),
    .strobe_oe(DATA_VALID_STROBE_POS_OE), .scramble(OUTPUT_SCRAMBLE_SELECT),
    .cap_q(cap), .cap_cnt(cap_cnt));

  // ------------------------------------------------------------------
  // Clocks and converter stimulus
  // ------------------------------------------------------------------
  always #4 SYS_CLK = !SYS_CLK;
  initial
  begin
    #3;
    forever
      #32 SAMPLE_CLOCK_POS = !SAMPLE_CLOCK_POS;
  end
  always @(posedge SAMPLE_CLOCK_POS)
    n_rise++;
  // Code changes at each encode fall so it is steady at each encode rise
  always @(negedge SAMPLE_CLOCK_POS)
    src = gen(n_rise + 1);
  always @(cap_cnt)
    cap_rise = n_rise;

  function automatic logic [16:0] gen(input int k);
    return {k % 3 == 0, 16'(k * 32'h0000_9E37)};
  endfunction : gen

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic timeout();
    n_mismatch++;
    $display("Error at %0t: wait timed out", $time);
    results();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rises(input int n);
    repeat (n * 8) @(posedge SYS_CLK);
  endtask : rises

  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= wr;
    S_AXI_WVALID <= wr;
    S_AXI_BREADY <= wr;
    S_AXI_ARVALID <= !wr;
    S_AXI_RREADY <= !wr;
    for (i = 0; i < 50; i++)
    begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (wr ? S_AXI_BVALID : S_AXI_RVALID) break;
    end
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
    rd = S_AXI_RDATA;
    rs = wr ? S_AXI_BRESP : S_AXI_RRESP;
    if (i == 50) timeout();
  endtask : axi

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic reset_check();
    @(posedge SYS_CLK);
    check(SAMPLE_WORD_BITS_OE, 1'b0);
    check(IRQ, 1'b0);
    axi(1'b0, OFF_MASK, 32'h0);
    check(rd, 32'(MASK_RST));
    axi(1'b1, OFF_MASK, 32'h0000_0004);
    check(rs, RESP_OKAY);
    axi(1'b0, OFF_MASK, 32'h0);
    check(rd, 32'h0000_0004);
    axi(1'b0, 8'h40, 32'h0);
    check(rs, RESP_SLVERR);
    check(rd, 32'h0);
  endtask : reset_check

  task automatic output_off(input logic pd);
    int c;
    axi(1'b0, OFF_STATUS, 32'h0);
    if (pd) pins.pdn <= 1'b1;
    else pins.oe_n <= 1'b1;
    rises(2);
    c = cap_cnt;
    check(SAMPLE_WORD_BITS_OE, 1'b0);
    check(RANGE_EXCEEDED_FLAG_OE, 1'b0);
    check(DATA_VALID_STROBE_NEG_OE, 1'b0);
    check(ANALOG_POWER_DOWN, pd);
    check(IRQ, pd);
    axi(1'b0, OFF_PINS, 32'h0);
    check(rd, 32'(pins));
    rises(2);
    check(cap_cnt - c, 32'h0);
    pins.pdn <= 1'b0;
    pins.oe_n <= 1'b0;
    rises(2);
    check(SAMPLE_WORD_BITS_OE, 1'b1);
    check(RANGE_EXCEEDED_FLAG_OE, 1'b1);
    check(DATA_VALID_STROBE_NEG_OE, 1'b1);
    check(DATA_VALID_STROBE_NEG_O, !DATA_VALID_STROBE_POS_O);
    axi(1'b0, OFF_STATUS, 32'h0);
    check(rd[EV_PDN], pd);
    repeat (2) @(posedge SYS_CLK);
    check(IRQ, 1'b0);
  endtask : output_off

  task automatic stream(input logic [2:0] m);
    logic [16:0] e;
    int          c;
    pins.mode <= m[1:0];
    pins.scramble <= m[2];
    pins.dither <= m[0];
    pins.gain <= !m[2];
    // Words in flight may carry the old format
    rises(9);
    check(DITHER_ACTIVE, m[0]);
    check(GAIN_HIGH_RANGE, !m[2]);
    check(DUTY_STABILIZER_ON, m[1:0] != 2'h0);
    repeat (8)
    begin
      c = cap_cnt;
      for (int i = 0; i < 20 && cap_cnt == c; i++)
        @(posedge SYS_CLK);
      if (cap_cnt == c) timeout();
      e = gen(cap_rise - 7);
      e[15] = e[15] ^ m[1];
      check(cap, e);
    end
  endtask : stream

  initial
  begin
    pins = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    reset_check();
    output_off(1'b1);
    output_off(1'b0);
    for (int m = 0; m < 8; m++)
      stream(3'(m));
    results();
  end
endmodule : adp_output_port_tb
`default_nettype wire
